// file: core/dtc_consts.vh
// Register indices, field positions, reset values and timing counts of the dual timer block
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH
// ==================================================================
// Register indices (byte address is index times four)
`define DTC_IDX_TCTRL 10'h088
`define DTC_IDX_TMODE 10'h089
`define DTC_IDX_A_LOW 10'h08A
`define DTC_IDX_B_LOW 10'h08B
`define DTC_IDX_A_HIGH 10'h08C
`define DTC_IDX_B_HIGH 10'h08D
`define DTC_IDX_CKSEL 10'h08E
`define DTC_IDX_GCFG 10'h090
// ==================================================================
// Reset values
`define DTC_RST_BYTE 8'h00
`define DTC_RST_CFG 4'h0
// ==================================================================
// Clock select fields
`define DTC_CK_T3H 7
`define DTC_CK_T3L 6
`define DTC_CK_T2H 5
`define DTC_CK_T2L 4
`define DTC_CK_B_SYS 3
`define DTC_CK_A_SYS 2
`define DTC_CK_PRE_HI 1
`define DTC_CK_PRE_LO 0
// ==================================================================
// Control fields
`define DTC_TC_B_FLAG 7
`define DTC_TC_B_RUN 6
`define DTC_TC_A_FLAG 5
`define DTC_TC_A_RUN 4
// ==================================================================
// Mode fields
`define DTC_TM_B_GATE 7
`define DTC_TM_B_CNT 6
`define DTC_TM_B_MHI 5
`define DTC_TM_B_MLO 4
`define DTC_TM_A_GATE 3
`define DTC_TM_A_CNT 2
`define DTC_TM_A_MHI 1
`define DTC_TM_A_MLO 0
`define DTC_MODE_13 2'b00
`define DTC_MODE_16 2'b01
`define DTC_MODE_RELOAD 2'b10
`define DTC_MODE_SPLIT 2'b11
// ==================================================================
// Gate and interrupt config fields
`define DTC_GC_A_POL 0
`define DTC_GC_B_POL 1
`define DTC_GC_A_IEN 2
`define DTC_GC_B_IEN 3
// ==================================================================
// Prescaler codes and divide counts
`define DTC_PRE_DIV12 2'b00
`define DTC_PRE_DIV4 2'b01
`define DTC_PRE_DIV48 2'b10
`define DTC_PRE_EXT8 2'b11
`define DTC_DIV12_LAST 6'd11
`define DTC_DIV4_LAST 6'd3
`define DTC_DIV48_LAST 6'd47
`define DTC_EXT8_LAST 6'd7
// ==================================================================
// Bus responses
`define DTC_RESP_OKAY 2'b00
`define DTC_RESP_SLVERR 2'b10
`endif

// file: core/dtc_sync_edge.v
// Two-flop pin synchroniser with level and edge outputs
`default_nettype none
module dtc_sync_edge (
  input wire aclk,
  input wire aresetn,
  input wire pin_in,
  output wire level_out,
  output wire fall_out,
  output wire rise_out
);
  reg meta_q;
  reg sync_q;
  reg prev_q;
  // ==================================================================
  // Synchroniser; only sync_q and prev_q feed any logic
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign level_out = sync_q;
  assign fall_out = prev_q & ~sync_q;
  assign rise_out = ~prev_q & sync_q;
endmodule
`default_nettype wire

// file: core/dtc_timer.v
// Dual 16-bit counter/timer with shared prescaler and AXI4-Lite registers
//
// The AXI4-Lite slave port was chosen for this implementation.
`include "dtc_consts.vh"
`default_nettype none
module dtc_timer (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  output wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [11:0] s_axi_araddr,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  input wire count_pin_a,
  input wire count_pin_b,
  input wire gate_input_a,
  input wire gate_input_b,
  input wire ext_osc_clk,
  input wire tmr_a_irq_ack,
  input wire tmr_b_irq_ack,
  input wire t2_xclk_tick,
  input wire t2_split,
  input wire t3_xclk_tick,
  input wire t3_split,
  output wire tmr_a_irq,
  output wire tmr_b_irq,
  output wire tmr_b_ovf_tick,
  output wire t2_low_tick,
  output wire t2_high_tick,
  output wire t3_low_tick,
  output wire t3_high_tick
);
  // ==================================================================
  // Registers
  reg [7:0] timer_clock_select_q;
  reg [7:0] timer_mode_reg_q;
  reg [7:0] tmr_a_low_byte_q;
  reg [7:0] tmr_a_high_byte_q;
  reg [7:0] tmr_b_low_byte_q;
  reg [7:0] tmr_b_high_byte_q;
  reg tmr_a_run_q;
  reg tmr_b_run_q;
  reg tmr_a_overflow_flag_q;
  reg tmr_b_overflow_flag_q;
  reg [3:0] gate_cfg_q;
  reg [5:0] pre_cnt_q;
  reg tmr_a_irq_q;
  reg tmr_b_irq_q;
  reg b_tick_q;
  reg t2l_q;
  reg t2h_q;
  reg t3l_q;
  reg t3h_q;
  // ==================================================================
  // Pin synchronisers
  wire pin_a_fall;
  wire pin_b_fall;
  wire gate_a_lvl;
  wire gate_b_lvl;
  wire osc_rise;
  dtc_sync_edge u_pin_a (.aclk(aclk), .aresetn(aresetn), .pin_in(count_pin_a),
    .level_out(), .fall_out(pin_a_fall), .rise_out());
  dtc_sync_edge u_pin_b (.aclk(aclk), .aresetn(aresetn), .pin_in(count_pin_b),
    .level_out(), .fall_out(pin_b_fall), .rise_out());
  dtc_sync_edge u_gate_a (.aclk(aclk), .aresetn(aresetn), .pin_in(gate_input_a),
    .level_out(gate_a_lvl), .fall_out(), .rise_out());
  dtc_sync_edge u_gate_b (.aclk(aclk), .aresetn(aresetn), .pin_in(gate_input_b),
    .level_out(gate_b_lvl), .fall_out(), .rise_out());
  dtc_sync_edge u_osc (.aclk(aclk), .aresetn(aresetn), .pin_in(ext_osc_clk),
    .level_out(), .fall_out(), .rise_out(osc_rise));
  // ==================================================================
  // Shared prescaler
  wire [1:0] prescale_select;
  reg [5:0] pre_last;
  wire pre_step;
  wire pre_tick;
  assign prescale_select = timer_clock_select_q[`DTC_CK_PRE_HI:`DTC_CK_PRE_LO];
  always @*
  begin
    case (prescale_select)
      `DTC_PRE_DIV12: pre_last = `DTC_DIV12_LAST;
      `DTC_PRE_DIV4: pre_last = `DTC_DIV4_LAST;
      `DTC_PRE_DIV48: pre_last = `DTC_DIV48_LAST;
      default: pre_last = `DTC_EXT8_LAST;
    endcase
  end
  // External clock advances the count only on its synchronised rising edge
  assign pre_step = (prescale_select == `DTC_PRE_EXT8) ? osc_rise : 1'b1;
  assign pre_tick = pre_step && (pre_cnt_q >= pre_last);
  always @(posedge aclk)
  begin
    if (!aresetn)
      pre_cnt_q <= 6'd0;
    else if (pre_tick)
      pre_cnt_q <= 6'd0;
    else if (pre_step)
      pre_cnt_q <= pre_cnt_q + 6'd1;
  end
  // ==================================================================
  // Per-timer enables and ticks
  wire [1:0] mode_a;
  wire [1:0] mode_b;
  wire split_a;
  wire int_tick_a;
  wire int_tick_b;
  wire run_a;
  wire run_b;
  wire tick_a;
  wire tick_b;
  wire gate_a_act;
  wire gate_b_act;
  assign mode_a = timer_mode_reg_q[`DTC_TM_A_MHI:`DTC_TM_A_MLO];
  assign mode_b = timer_mode_reg_q[`DTC_TM_B_MHI:`DTC_TM_B_MLO];
  assign split_a = (mode_a == `DTC_MODE_SPLIT);
  assign int_tick_a = timer_clock_select_q[`DTC_CK_A_SYS] | pre_tick;
  assign int_tick_b = timer_clock_select_q[`DTC_CK_B_SYS] | pre_tick;
  assign gate_a_act = (gate_a_lvl == gate_cfg_q[`DTC_GC_A_POL]);
  assign gate_b_act = (gate_b_lvl == gate_cfg_q[`DTC_GC_B_POL]);
  assign run_a = tmr_a_run_q && (!timer_mode_reg_q[`DTC_TM_A_GATE] || gate_a_act);
  // Split mode: timer 1 runs on its mode alone and never sees its pin
  assign run_b = (mode_b != `DTC_MODE_SPLIT) &&
    (split_a || (tmr_b_run_q && (!timer_mode_reg_q[`DTC_TM_B_GATE] || gate_b_act)));
  assign tick_a = timer_mode_reg_q[`DTC_TM_A_CNT] ? pin_a_fall : int_tick_a;
  assign tick_b = (timer_mode_reg_q[`DTC_TM_B_CNT] && !split_a) ? pin_b_fall : int_tick_b;
  // ==================================================================
  // Count step shared by both timers: returns {overflow, high, low}
  function [16:0] dtc_step;
    input [1:0] mode;
    input [7:0] hi;
    input [7:0] lo;
    reg [12:0] c13;
    reg [15:0] c16;
    begin
      c13 = {hi, lo[4:0]} + 13'd1;
      c16 = {hi, lo} + 16'd1;
      case (mode)
        `DTC_MODE_13:
          dtc_step = {({hi, lo[4:0]} == 13'h1FFF), c13[12:5], lo[7:5], c13[4:0]};
        `DTC_MODE_16:
          dtc_step = {({hi, lo} == 16'hFFFF), c16};
        `DTC_MODE_RELOAD:
          if (lo == 8'hFF)
            dtc_step = {1'b1, hi, hi};
          else
            dtc_step = {1'b0, hi, lo + 8'h01};
        default:
          dtc_step = {(lo == 8'hFF), hi, lo + 8'h01};
      endcase
    end
  endfunction
  reg [7:0] a_lo_d;
  reg [7:0] a_hi_d;
  reg [7:0] b_lo_d;
  reg [7:0] b_hi_d;
  reg set_a_flag;
  reg set_b_flag;
  reg b_ovf;
  reg [16:0] step_a;
  reg [16:0] step_b;
  always @*
  begin
    step_a = dtc_step(mode_a, tmr_a_high_byte_q, tmr_a_low_byte_q);
    step_b = dtc_step(mode_b, tmr_b_high_byte_q, tmr_b_low_byte_q);
    a_lo_d = tmr_a_low_byte_q;
    a_hi_d = tmr_a_high_byte_q;
    b_lo_d = tmr_b_low_byte_q;
    b_hi_d = tmr_b_high_byte_q;
    set_a_flag = 1'b0;
    set_b_flag = 1'b0;
    b_ovf = 1'b0;
    if (run_a && tick_a)
    begin
      a_lo_d = step_a[7:0];
      if (!split_a)
        a_hi_d = step_a[15:8];
      set_a_flag = step_a[16];
    end
    // Split high byte: internal clock only, started by timer 1 run bit
    if (split_a && tmr_b_run_q && int_tick_a)
    begin
      a_hi_d = tmr_a_high_byte_q + 8'h01;
      set_b_flag = (tmr_a_high_byte_q == 8'hFF);
    end
    if (run_b && tick_b)
    begin
      b_lo_d = step_b[7:0];
      b_hi_d = step_b[15:8];
      b_ovf = step_b[16];
      if (!split_a)
        set_b_flag = step_b[16];
    end
  end
  // ==================================================================
  // AXI4-Lite slave
  reg aw_held_q;
  reg w_held_q;
  reg awready_q;
  reg wready_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg [9:0] aw_idx_q;
  reg [7:0] wbyte_q;
  reg wlane_q;
  reg arready_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  wire aw_fire;
  wire w_fire;
  wire wr_do;
  wire aw_held_d;
  wire w_held_d;
  assign aw_fire = s_axi_awvalid && awready_q;
  assign w_fire = s_axi_wvalid && wready_q;
  assign wr_do = aw_held_q && w_held_q && !bvalid_q;
  assign aw_held_d = aw_fire | (aw_held_q & ~wr_do);
  assign w_held_d = w_fire | (w_held_q & ~wr_do);
  // Byte lane 0 must be strobed for a register to change
  wire wr_en;
  assign wr_en = wr_do && wlane_q;
  wire wr_tctrl;
  wire wr_tmode;
  wire wr_a_lo;
  wire wr_a_hi;
  wire wr_b_lo;
  wire wr_b_hi;
  wire wr_cksel;
  wire wr_gcfg;
  assign wr_tctrl = wr_en && (aw_idx_q == `DTC_IDX_TCTRL);
  assign wr_tmode = wr_en && (aw_idx_q == `DTC_IDX_TMODE);
  assign wr_a_lo = wr_en && (aw_idx_q == `DTC_IDX_A_LOW);
  assign wr_a_hi = wr_en && (aw_idx_q == `DTC_IDX_A_HIGH);
  assign wr_b_lo = wr_en && (aw_idx_q == `DTC_IDX_B_LOW);
  assign wr_b_hi = wr_en && (aw_idx_q == `DTC_IDX_B_HIGH);
  assign wr_cksel = wr_en && (aw_idx_q == `DTC_IDX_CKSEL);
  assign wr_gcfg = wr_en && (aw_idx_q == `DTC_IDX_GCFG);
  function dtc_mapped;
    input [9:0] idx;
    begin
      dtc_mapped = (idx >= `DTC_IDX_TCTRL && idx <= `DTC_IDX_CKSEL) || (idx == `DTC_IDX_GCFG);
    end
  endfunction
  reg [7:0] rd_byte;
  wire [9:0] ar_idx;
  assign ar_idx = s_axi_araddr[11:2];
  always @*
  begin
    case (ar_idx)
      `DTC_IDX_TCTRL: rd_byte = {tmr_b_overflow_flag_q, tmr_b_run_q, tmr_a_overflow_flag_q, tmr_a_run_q, 4'h0};
      `DTC_IDX_TMODE: rd_byte = timer_mode_reg_q;
      `DTC_IDX_A_LOW: rd_byte = tmr_a_low_byte_q;
      `DTC_IDX_A_HIGH: rd_byte = tmr_a_high_byte_q;
      `DTC_IDX_B_LOW: rd_byte = tmr_b_low_byte_q;
      `DTC_IDX_B_HIGH: rd_byte = tmr_b_high_byte_q;
      `DTC_IDX_CKSEL: rd_byte = timer_clock_select_q;
      `DTC_IDX_GCFG: rd_byte = {4'h0, gate_cfg_q};
      default: rd_byte = 8'h00;
    endcase
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `DTC_RESP_OKAY;
      aw_idx_q <= 10'd0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `DTC_RESP_OKAY;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awready_q <= ~aw_held_d;
      wready_q <= ~w_held_d;
      if (aw_fire)
        aw_idx_q <= s_axi_awaddr[11:2];
      if (w_fire)
      begin
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      if (wr_do)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= dtc_mapped(aw_idx_q) ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
      if (s_axi_arvalid && arready_q)
      begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= {24'h000000, rd_byte};
        rresp_q <= dtc_mapped(ar_idx) ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
      end
      else if (rvalid_q && s_axi_rready)
      begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
      else if (!rvalid_q)
        arready_q <= 1'b1;
    end
  end
  // ==================================================================
  // Register file and counters; a bus write beats a count in that byte
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_clock_select_q <= `DTC_RST_BYTE;
      timer_mode_reg_q <= `DTC_RST_BYTE;
      tmr_a_low_byte_q <= `DTC_RST_BYTE;
      tmr_a_high_byte_q <= `DTC_RST_BYTE;
      tmr_b_low_byte_q <= `DTC_RST_BYTE;
      tmr_b_high_byte_q <= `DTC_RST_BYTE;
      tmr_a_run_q <= 1'b0;
      tmr_b_run_q <= 1'b0;
      tmr_a_overflow_flag_q <= 1'b0;
      tmr_b_overflow_flag_q <= 1'b0;
      gate_cfg_q <= `DTC_RST_CFG;
    end
    else
    begin
      if (wr_cksel)
        timer_clock_select_q <= wbyte_q;
      if (wr_tmode)
        timer_mode_reg_q <= wbyte_q;
      if (wr_gcfg)
        gate_cfg_q <= wbyte_q[3:0];
      if (wr_tctrl)
      begin
        tmr_a_run_q <= wbyte_q[`DTC_TC_A_RUN];
        tmr_b_run_q <= wbyte_q[`DTC_TC_B_RUN];
      end
      tmr_a_low_byte_q <= wr_a_lo ? wbyte_q : a_lo_d;
      tmr_a_high_byte_q <= wr_a_hi ? wbyte_q : a_hi_d;
      tmr_b_low_byte_q <= wr_b_lo ? wbyte_q : b_lo_d;
      tmr_b_high_byte_q <= wr_b_hi ? wbyte_q : b_hi_d;
      // Hardware set wins over a software clear or a vector acknowledge
      if (set_a_flag)
        tmr_a_overflow_flag_q <= 1'b1;
      else if (wr_tctrl)
        tmr_a_overflow_flag_q <= wbyte_q[`DTC_TC_A_FLAG];
      else if (tmr_a_irq_ack)
        tmr_a_overflow_flag_q <= 1'b0;
      if (set_b_flag)
        tmr_b_overflow_flag_q <= 1'b1;
      else if (wr_tctrl)
        tmr_b_overflow_flag_q <= wbyte_q[`DTC_TC_B_FLAG];
      else if (tmr_b_irq_ack)
        tmr_b_overflow_flag_q <= 1'b0;
    end
  end
  // ==================================================================
  // Registered outputs: requests, overflow tick, timer 2/3 clock ticks
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tmr_a_irq_q <= 1'b0;
      tmr_b_irq_q <= 1'b0;
      b_tick_q <= 1'b0;
      t2l_q <= 1'b0;
      t2h_q <= 1'b0;
      t3l_q <= 1'b0;
      t3h_q <= 1'b0;
    end
    else
    begin
      tmr_a_irq_q <= tmr_a_overflow_flag_q & gate_cfg_q[`DTC_GC_A_IEN];
      tmr_b_irq_q <= tmr_b_overflow_flag_q & gate_cfg_q[`DTC_GC_B_IEN];
      b_tick_q <= b_ovf;
      t2l_q <= timer_clock_select_q[`DTC_CK_T2L] | t2_xclk_tick;
      t2h_q <= t2_split ? (timer_clock_select_q[`DTC_CK_T2H] | t2_xclk_tick)
        : (timer_clock_select_q[`DTC_CK_T2L] | t2_xclk_tick);
      t3l_q <= timer_clock_select_q[`DTC_CK_T3L] | t3_xclk_tick;
      t3h_q <= t3_split ? (timer_clock_select_q[`DTC_CK_T3H] | t3_xclk_tick)
        : (timer_clock_select_q[`DTC_CK_T3L] | t3_xclk_tick);
    end
  end
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign tmr_a_irq = tmr_a_irq_q;
  assign tmr_b_irq = tmr_b_irq_q;
  assign tmr_b_ovf_tick = b_tick_q;
  assign t2_low_tick = t2l_q;
  assign t2_high_tick = t2h_q;
  assign t3_low_tick = t3l_q;
  assign t3_high_tick = t3h_q;
endmodule
`default_nettype wire

// file: verification/dtc_pin_model.sv
// Behavioural model of the timer's count, gate and oscillator pins
`default_nettype none
module dtc_pin_model (
  input wire logic aclk,
  output logic count_pin_a,
  output logic count_pin_b,
  output logic gate_input_a,
  output logic gate_input_b,
  output logic ext_osc_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    count_pin_a = 1'b1;
    count_pin_b = 1'b1;
    gate_input_a = 1'b0;
    gate_input_b = 1'b0;
    ext_osc_clk = 1'b0;
  end
  // Oscillator runs free, its period unrelated to aclk
  always #135 ext_osc_clk = ~ext_osc_clk;
  // Each level stands three cycles, above the two-cycle sampling minimum
  task automatic edges(input logic sel, input int n);
    repeat (n)
    begin
      repeat (3) @(posedge aclk);
      if (sel)
        count_pin_b <= 1'b0;
      else
        count_pin_a <= 1'b0;
      repeat (3) @(posedge aclk);
      if (sel)
        count_pin_b <= 1'b1;
      else
        count_pin_a <= 1'b1;
    end
  endtask
  task automatic gate(input logic sel, input logic lvl);
    @(posedge aclk);
    if (sel)
      gate_input_b <= lvl;
    else
      gate_input_a <= lvl;
  endtask
endmodule
`default_nettype wire

// file: verification/dtc_timer_chk.sv
// Bus, reset and clock-select checks on the dual timer's ports
`default_nettype none
module dtc_timer_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic tmr_a_irq,
  input wire logic tmr_b_irq,
  input wire logic t2_split,
  input wire logic t2_low_tick,
  input wire logic t2_high_tick,
  input wire logic t3_xclk_tick,
  input wire logic t3_split,
  input wire logic t3_low_tick,
  input wire logic t3_high_tick
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !tmr_a_irq && !tmr_b_irq)
    else $error("outputs active after a reset edge");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address accepted");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after take");
  a_t2_mirror: assert property (!t2_split |=> t2_high_tick == t2_low_tick)
    else $error("timer 2 high tick differs from low outside split");
  a_t3_split_high: assert property (t3_xclk_tick && t3_split |=> t3_high_tick)
    else $error("timer 3 high tick missing in split");
  a_t3_low_follow: assert property (t3_xclk_tick |=> t3_low_tick)
    else $error("timer 3 low tick missing after its clock tick");
endmodule
`default_nettype wire

// file: verification/test_dtc_timer.sv
// Self-checking bench of the dual timer through its register bus and pins
`include "dtc_consts.vh"
`default_nettype none
module test_dtc_timer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] TC = `DTC_IDX_TCTRL, TM = `DTC_IDX_TMODE, AL = `DTC_IDX_A_LOW, BL = `DTC_IDX_B_LOW;
  localparam logic [9:0] AH = `DTC_IDX_A_HIGH, BH = `DTC_IDX_B_HIGH, CK = `DTC_IDX_CKSEL, GC = `DTC_IDX_GCFG;
  localparam logic [31:0] SLV = 32'(`DTC_RESP_SLVERR);
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic ack_a = 1'b0, t2x = 1'b0, t3x = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h00000000, v, v0;
  logic [1:0] resp;
  logic [9:0] rl [8] = '{TC, TM, AL, BL, AH, BH, CK, GC};
  wire awr, wrd, bv, arr, rv, ia, ib, bt, pa, pb, ga, gb, osc;
  wire [1:0] br, rr;
  wire [31:0] rd;
  int fails = 0, check_count = 0, cyc = 0, bticks = 0, ew, e0, e1, b0, ex, cnt;
  int dv [4] = '{12, 4, 48, 1};
  always #50 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    t2x <= cyc[2];
    t3x <= cyc[3];
    if (bt) bticks <= bticks + 1;
  end
  dtc_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rd), .s_axi_rresp(rr), .count_pin_a(pa),
    .count_pin_b(pb), .gate_input_a(ga), .gate_input_b(gb), .ext_osc_clk(osc), .tmr_a_irq_ack(ack_a),
    .tmr_b_irq_ack(1'b0), .t2_xclk_tick(t2x), .t2_split(1'b0), .t3_xclk_tick(t3x), .t3_split(1'b1),
    .tmr_a_irq(ia), .tmr_b_irq(ib), .tmr_b_ovf_tick(bt), .t2_low_tick(), .t2_high_tick(), .t3_low_tick(),
    .t3_high_tick());
  dtc_pin_model pins (.aclk(aclk), .count_pin_a(pa), .count_pin_b(pb), .gate_input_a(ga), .gate_input_b(gb),
    .ext_osc_clk(osc));
  // ==========================================================
  // Bus tasks and comparison
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Records the edge count at the response so callers can time run spans
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    @(posedge aclk);
    awa <= {idx, 2'b00};
    wd <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
    end
    while (!(bv && bre));
    resp = br;
    ew = cyc;
    bre <= 1'b0;
  endtask
  task automatic rdr(input logic [9:0] idx);
    @(posedge aclk);
    ara <= {idx, 2'b00};
    arv <= 1'b1;
    rre <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
    end
    while (!(rv && rre));
    v = rd;
    resp = rr;
    rre <= 1'b0;
  endtask
  task automatic rc(input logic [9:0] idx, input logic [31:0] exp);
    rdr(idx);
    check(v, exp);
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #2000000;
    fails++;
    test_done;
  end
  // ==========================================================
  // Test sequence
  initial
  begin
    cy(4);
    aresetn <= 1'b1;
    cy(1);
    foreach (rl[i]) rc(rl[i], 32'h0);
    wr(CK, 8'hFC);
    rc(CK, 32'hFC);
    wr(10'h0FF, 8'h55);
    check(32'(resp), SLV);
    rdr(10'h0FF);
    check(32'(resp), SLV);
    $display("test registers done");
    wr(CK, 8'h04);
    wr(GC, 8'h04);
    wr(AH, 8'hFF);
    wr(AL, 8'h1F);
    wr(TC, 8'h10);
    e0 = ew;
    rc(TC, 32'h30);
    #1 check(32'(ia), 32'h1);
    @(posedge aclk);
    ack_a <= 1'b1;
    @(posedge aclk);
    ack_a <= 1'b0;
    cy(2);
    #1 check(32'(ia), 32'h0);
    rc(TC, 32'h10);
    wr(TC, 8'h00);
    e1 = ew - e0 - 1;
    rc(AH, 32'(e1 >> 5));
    rdr(AL);
    check(v & 32'h1F, 32'(e1 & 31));
    $display("test 13-bit done");
    wr(TM, 8'h01);
    for (int c = 0; c < 4; c++)
    begin
      wr(CK, 8'(c));
      wr(AL, 8'h00);
      wr(AH, 8'h00);
      wr(TC, 8'h10);
      e0 = ew;
      cy(480);
      wr(TC, 8'h00);
      e1 = ew - e0;
      rdr(AL);
      v0 = v;
      rdr(AH);
      cnt = int'({v[7:0], v0[7:0]});
      ex = (c == 3) ? e1 * 100 / 2160 : e1 / dv[c];
      check(32'(cnt >= ex - 1 && cnt <= ex + 2), 32'h1);
    end
    $display("test prescaler done");
    wr(TM, 8'hD0);
    wr(GC, 8'h02);
    wr(TC, 8'h40);
    pins.edges(1'b1, 3);
    rc(BL, 32'h0);
    pins.gate(1'b1, 1'b1);
    pins.edges(1'b1, 5);
    cy(4);
    rc(BL, 32'h5);
    wr(TC, 8'h00);
    $display("test counter done");
    wr(TM, 8'h20);
    wr(CK, 8'h08);
    wr(GC, 8'h00);
    wr(BH, 8'hFC);
    wr(BL, 8'hFE);
    wr(TC, 8'h40);
    e0 = ew;
    rc(TC, 32'hC0);
    #1 check(32'(ib), 32'h0);
    wr(TC, 8'h80);
    e1 = ew - e0;
    rc(BH, 32'hFC);
    rc(BL, 32'(252 + (e1 - 2) % 4));
    wr(GC, 8'h08);
    cy(2);
    #1 check(32'(ib), 32'h1);
    wr(TC, 8'h00);
    cy(2);
    #1 check(32'(ib), 32'h0);
    $display("test reload done");
    wr(TM, 8'h03);
    wr(CK, 8'h0C);
    wr(AL, 8'h00);
    wr(AH, 8'hF0);
    b0 = bticks;
    wr(BH, 8'hFF);
    wr(BL, 8'h1F);
    cy(8);
    check(32'(bticks > b0), 32'h1);
    rc(TC, 32'h0);
    wr(TC, 8'h40);
    cy(250);
    rc(TC, 32'hC0);
    rc(AL, 32'h0);
    wr(TM, 8'h33);
    rdr(BL);
    v0 = v;
    rdr(BL);
    check(v, v0);
    $display("test split done");
    test_done;
  end
endmodule
bind dtc_timer dtc_timer_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .tmr_a_irq, .tmr_b_irq, .t2_split, .t2_low_tick, .t2_high_tick, .t3_xclk_tick, .t3_split,
  .t3_low_tick, .t3_high_tick);
`default_nettype wire
